/* nvm_prog_device.sv */
// Device end of the parallel programming port: command decode and NVM state.
// Assumes the programmer keeps data stable a cycle before the strobe falls.
`timescale 1ns/1ns
`default_nettype none
module nvm_prog_device #(
    parameter int DETECT_CYC = 3 * nvm_port_pkg::EXT_PERIOD_MAX_CYC,
    // Version word, arbitrary value
    parameter nvm_port_pkg::word_t VERSION_CODE = 16'h0001
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Programmer link
    nvm_port_if.device link,
    // State seen by the rest of the chip
    output logic o_ext_clock_sel,
    output nvm_port_pkg::word_t o_lock_bits,
    output nvm_port_pkg::word_t o_gp_bits,
    output logic o_security,
    output logic o_cmd_ignored
);
    typedef enum logic [1:0] {
        ST_DETECT = 2'b00,
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10,
        ST_RELEASE = 2'b11
    } dev_state_t;

    dev_state_t state_reg, state_next;
    logic strobe_s1_reg, strobe_s2_reg, strobe_d_reg;
    logic rsel_s1_reg, rsel_s2_reg;
    logic ext_s1_reg, ext_s2_reg, ext_d_reg;
    nvm_port_pkg::word_t data_s1_reg, data_s2_reg;
    nvm_port_pkg::count_t cnt_reg, cnt_next;
    nvm_port_pkg::count_t gap_reg, gap_next;
    logic edge_seen_reg, edge_seen_next;
    logic fast_reg, fast_next;
    logic ext_sel_reg, ext_sel_next;
    logic pend_reg, pend_next;
    nvm_port_pkg::word_t pcmd_reg, pcmd_next;
    nvm_port_pkg::word_t result_reg, result_next;
    nvm_port_pkg::word_t wbuf_reg, wbuf_next;
    nvm_port_pkg::word_t lock_reg, lock_next;
    nvm_port_pkg::word_t gp_reg, gp_next;
    logic sec_reg, sec_next;
    logic oe_reg, oe_next;
    logic ign_reg, ign_next;
    nvm_port_pkg::word_t mem_reg [nvm_port_pkg::PAGES];
    nvm_port_pkg::word_t mem_next [nvm_port_pkg::PAGES];
    logic strobe_fall;
    logic ext_rise;
    logic [nvm_port_pkg::PAGE_IDX_W-1:0] idx;

    // Pins come from another party, so two flops before any logic reads them
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strobe_s1_reg <= 1'b1;
            strobe_s2_reg <= 1'b1;
            strobe_d_reg <= 1'b1;
            rsel_s1_reg <= 1'b0;
            rsel_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_d_reg <= 1'b0;
            data_s1_reg <= nvm_port_pkg::ZERO_WORD;
            data_s2_reg <= nvm_port_pkg::ZERO_WORD;
        end else begin
            strobe_s1_reg <= link.command_strobe_n;
            strobe_s2_reg <= strobe_s1_reg;
            strobe_d_reg <= strobe_s2_reg;
            rsel_s1_reg <= link.read_select;
            rsel_s2_reg <= rsel_s1_reg;
            ext_s1_reg <= link.external_clock_input;
            ext_s2_reg <= ext_s1_reg;
            ext_d_reg <= ext_s2_reg;
            data_s1_reg <= link.data_bus;
            data_s2_reg <= data_s1_reg;
        end
    end

    // Edges of the synchronised pins
    assign strobe_fall = strobe_d_reg & ~strobe_s2_reg;
    assign ext_rise = ext_s2_reg & ~ext_d_reg;
    assign idx = data_s2_reg[nvm_port_pkg::PAGE_IDX_W-1:0];

    // Next state of the handshake, clock check and NVM contents
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        gap_next = gap_reg;
        edge_seen_next = edge_seen_reg;
        fast_next = fast_reg;
        ext_sel_next = ext_sel_reg;
        pend_next = pend_reg;
        pcmd_next = pcmd_reg;
        result_next = result_reg;
        wbuf_next = wbuf_reg;
        lock_next = lock_reg;
        gp_next = gp_reg;
        sec_next = sec_reg;
        oe_next = oe_reg;
        ign_next = 1'b0;
        mem_next = mem_reg;
        // Gap between external clock edges; saturates so a stopped clock never wraps
        if (ext_rise) begin
            gap_next = nvm_port_pkg::ZERO_COUNT;
            edge_seen_next = 1'b1;
            if (edge_seen_reg && gap_reg < nvm_port_pkg::count_t'(nvm_port_pkg::EXT_PERIOD_MAX_CYC)) begin
                fast_next = 1'b1;
            end
        end else if (gap_reg != {nvm_port_pkg::CNT_W{1'b1}}) begin
            gap_next = gap_reg + nvm_port_pkg::ONE_COUNT;
        end
        unique case (state_reg)
            ST_DETECT: begin
                // Ready stays low until the clock source is settled
                cnt_next = cnt_reg + nvm_port_pkg::ONE_COUNT;
                if (cnt_reg == nvm_port_pkg::count_t'(DETECT_CYC - 1)) begin
                    ext_sel_next = fast_next;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (strobe_fall) begin
                    state_next = ST_EXEC;
                    cnt_next = nvm_port_pkg::ZERO_COUNT;
                    if (rsel_s2_reg) begin
                        oe_next = 1'b1;
                    end else if (pend_reg) begin
                        // Argument word for a command taken earlier
                        pend_next = 1'b0;
                        case (pcmd_reg)
                            nvm_port_pkg::CMD_ERASE_WRITE_LOCK: begin
                                if (lock_reg[idx]) begin
                                    ign_next = 1'b1;
                                end else begin
                                    mem_next[idx] = wbuf_reg;
                                    lock_next[idx] = 1'b1;
                                end
                            end
                            nvm_port_pkg::CMD_WRITE_MEMORY: wbuf_next = data_s2_reg;
                            nvm_port_pkg::CMD_SET_LOCK: lock_next[idx] = 1'b1;
                            nvm_port_pkg::CMD_SET_GP_BIT: gp_next[idx] = 1'b1;
                            nvm_port_pkg::CMD_CLEAR_LOCK: lock_next[idx] = 1'b0;
                            default: gp_next[idx] = 1'b0;
                        endcase
                    end else begin
                        case (data_s2_reg)
                            nvm_port_pkg::CMD_ERASE_WRITE_LOCK,
                            nvm_port_pkg::CMD_WRITE_MEMORY,
                            nvm_port_pkg::CMD_SET_LOCK,
                            nvm_port_pkg::CMD_SET_GP_BIT,
                            nvm_port_pkg::CMD_CLEAR_LOCK,
                            nvm_port_pkg::CMD_CLEAR_GP_BIT: begin
                                pend_next = 1'b1;
                                pcmd_next = data_s2_reg;
                            end
                            nvm_port_pkg::CMD_ERASE_ALL: begin
                                for (int i = 0; i < nvm_port_pkg::PAGES; i++) begin
                                    mem_next[i] = nvm_port_pkg::ZERO_WORD;
                                end
                                lock_next = nvm_port_pkg::ZERO_WORD;
                                wbuf_next = nvm_port_pkg::ZERO_WORD;
                                sec_next = 1'b0;
                            end
                            nvm_port_pkg::CMD_SET_SECURITY: sec_next = 1'b1;
                            nvm_port_pkg::CMD_GET_LOCK: result_next = lock_reg;
                            nvm_port_pkg::CMD_GET_GP_BIT: result_next = gp_reg;
                            nvm_port_pkg::CMD_GET_SECURITY: begin
                                result_next = nvm_port_pkg::word_t'(sec_reg);
                            end
                            nvm_port_pkg::CMD_GET_VERSION: result_next = VERSION_CODE;
                            nvm_port_pkg::CMD_SELECT_CONTROLLER: begin
                            end
                            default: ign_next = 1'b1;
                        endcase
                    end
                end
            end
            ST_EXEC: begin
                // Busy time; ready is low throughout
                cnt_next = cnt_reg + nvm_port_pkg::ONE_COUNT;
                if (cnt_reg == nvm_port_pkg::count_t'(nvm_port_pkg::EXEC_CYC - 1)) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Ready comes back only once the strobe is high again
                if (strobe_s2_reg) begin
                    oe_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // Register the next values
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_DETECT;
            cnt_reg <= nvm_port_pkg::ZERO_COUNT;
            gap_reg <= nvm_port_pkg::ZERO_COUNT;
            edge_seen_reg <= 1'b0;
            fast_reg <= 1'b0;
            ext_sel_reg <= 1'b0;
            pend_reg <= 1'b0;
            pcmd_reg <= nvm_port_pkg::ZERO_WORD;
            result_reg <= nvm_port_pkg::ZERO_WORD;
            wbuf_reg <= nvm_port_pkg::ZERO_WORD;
            lock_reg <= nvm_port_pkg::ZERO_WORD;
            gp_reg <= nvm_port_pkg::ZERO_WORD;
            sec_reg <= 1'b0;
            oe_reg <= 1'b0;
            ign_reg <= 1'b0;
            for (int i = 0; i < nvm_port_pkg::PAGES; i++) begin
                mem_reg[i] <= nvm_port_pkg::ZERO_WORD;
            end
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            gap_reg <= gap_next;
            edge_seen_reg <= edge_seen_next;
            fast_reg <= fast_next;
            ext_sel_reg <= ext_sel_next;
            pend_reg <= pend_next;
            pcmd_reg <= pcmd_next;
            result_reg <= result_next;
            wbuf_reg <= wbuf_next;
            lock_reg <= lock_next;
            gp_reg <= gp_next;
            sec_reg <= sec_next;
            oe_reg <= oe_next;
            ign_reg <= ign_next;
            mem_reg <= mem_next;
        end
    end

    // Outputs
    assign link.ready = (state_reg == ST_IDLE);
    assign link.dev_data = result_reg;
    assign link.dev_oe = oe_reg;
    assign o_ext_clock_sel = ext_sel_reg;
    assign o_lock_bits = lock_reg;
    assign o_gp_bits = gp_reg;
    assign o_security = sec_reg;
    assign o_cmd_ignored = ign_reg;
endmodule : nvm_prog_device
`default_nettype wire

/* nvm_port_pkg.sv */
// Constants shared by both ends of the parallel programming port.
// Assumes both ends run from the same 50 MHz system clock.
package nvm_port_pkg;
    // Clock
    localparam int CLK_PERIOD_NS = 20;
    // External clock presence threshold, as a frequency and a longest period
    localparam int EXT_MIN_FREQ_KHZ = 32;
    localparam int EXT_PERIOD_MAX_NS = 1000000 / EXT_MIN_FREQ_KHZ;
    localparam int EXT_PERIOD_MAX_CYC = EXT_PERIOD_MAX_NS / CLK_PERIOD_NS;
    // Time the device stays busy on each operation
    localparam int EXEC_NS = 200;
    localparam int EXEC_CYC = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Power-on-reset delay the programmer waits out
    localparam int POR_NS = 100000;
    localparam int POR_CYC = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // External clock the programmer may supply
    localparam int EXT_FREQ_KHZ = 1000;
    localparam int EXT_HALF_NS = 500000 / EXT_FREQ_KHZ;
    localparam int EXT_HALF_CYC = EXT_HALF_NS / CLK_PERIOD_NS;
    // Data path and memory shape
    localparam int WORD_W = 16;
    localparam int PAGES = 16;
    localparam int PAGE_IDX_W = 4;
    localparam int CNT_W = 16;
    typedef logic [WORD_W-1:0] word_t;
    typedef logic [CNT_W-1:0] count_t;
    localparam word_t ZERO_WORD = 16'h0000;
    localparam count_t ZERO_COUNT = 16'h0000;
    localparam count_t ONE_COUNT = 16'h0001;
    // Command codes
    localparam word_t CMD_ERASE_WRITE_LOCK = 16'h0042;
    localparam word_t CMD_ERASE_ALL = 16'h0013;
    localparam word_t CMD_SET_LOCK = 16'h0014;
    localparam word_t CMD_CLEAR_LOCK = 16'h0024;
    localparam word_t CMD_GET_LOCK = 16'h0015;
    localparam word_t CMD_SET_GP_BIT = 16'h0034;
    localparam word_t CMD_CLEAR_GP_BIT = 16'h0044;
    localparam word_t CMD_GET_GP_BIT = 16'h0025;
    localparam word_t CMD_SET_SECURITY = 16'h0054;
    localparam word_t CMD_GET_SECURITY = 16'h0035;
    localparam word_t CMD_WRITE_MEMORY = 16'h001f;
    localparam word_t CMD_SELECT_CONTROLLER = 16'h0016;
    localparam word_t CMD_GET_VERSION = 16'h001e;
endpackage : nvm_port_pkg

/* nvm_port_if.sv */
// Pins between the device's programming port and the external programmer.
// Assumes both ends share one clock; the data bus is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface nvm_port_if;
    logic command_strobe_n;
    logic read_select;
    logic ready;
    logic external_clock_input;
    nvm_port_pkg::word_t host_data;
    logic host_oe;
    nvm_port_pkg::word_t dev_data;
    logic dev_oe;
    nvm_port_pkg::word_t data_bus;

    // Bus level: programmer wins, undriven bus reads low
    assign data_bus = host_oe ? host_data : (dev_oe ? dev_data : nvm_port_pkg::ZERO_WORD);

    modport device (
        input command_strobe_n,
        input read_select,
        input external_clock_input,
        input data_bus,
        output ready,
        output dev_data,
        output dev_oe
    );
    modport programmer (
        output command_strobe_n,
        output read_select,
        output external_clock_input,
        output host_data,
        output host_oe,
        input ready,
        input data_bus
    );
endinterface : nvm_port_if
`default_nettype wire

/* nvm_prog_host.sv */
// Programmer end of the parallel programming port.
// Assumes the device answers with ready as the handshake describes.
`timescale 1ns/1ns
`default_nettype none
module nvm_prog_host #(
    parameter int POR_CYC = nvm_port_pkg::POR_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Device link
    nvm_port_if.programmer link,
    // User requests
    input wire logic i_ext_clock_en,
    input wire logic i_start,
    input wire logic i_read,
    input wire nvm_port_pkg::word_t i_word,
    // User answers
    output logic o_req_ready,
    output logic o_done,
    output nvm_port_pkg::word_t o_rdata
);
    typedef enum logic [2:0] {
        H_POR = 3'b000,
        H_IDLE = 3'b001,
        H_WAITRDY = 3'b010,
        H_SETUP = 3'b011,
        H_LOW = 3'b100,
        H_HIGH = 3'b101
    } host_state_t;

    host_state_t state_reg, state_next;
    nvm_port_pkg::count_t cnt_reg, cnt_next;
    nvm_port_pkg::count_t div_reg, div_next;
    logic xclk_reg, xclk_next;
    logic rdy_s1_reg, rdy_s2_reg;
    nvm_port_pkg::word_t bus_s1_reg, bus_s2_reg;
    logic read_reg, read_next;
    nvm_port_pkg::word_t word_reg, word_next;
    logic strobe_n_reg, strobe_n_next;
    logic oe_reg, oe_next;
    logic done_reg, done_next;
    nvm_port_pkg::word_t rdata_reg, rdata_next;

    // Ready and data come from the device, so two flops first
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
            bus_s1_reg <= nvm_port_pkg::ZERO_WORD;
            bus_s2_reg <= nvm_port_pkg::ZERO_WORD;
        end else begin
            rdy_s1_reg <= link.ready;
            rdy_s2_reg <= rdy_s1_reg;
            bus_s1_reg <= link.data_bus;
            bus_s2_reg <= bus_s1_reg;
        end
    end

    // Next state of the handshake and the external clock divider
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        div_next = div_reg;
        xclk_next = xclk_reg;
        read_next = read_reg;
        word_next = word_reg;
        strobe_n_next = strobe_n_reg;
        oe_next = oe_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        // Clock runs from reset so it is there within the power-on delay
        if (!i_ext_clock_en) begin
            div_next = nvm_port_pkg::ZERO_COUNT;
            xclk_next = 1'b0;
        end else if (div_reg == nvm_port_pkg::count_t'(nvm_port_pkg::EXT_HALF_CYC - 1)) begin
            div_next = nvm_port_pkg::ZERO_COUNT;
            xclk_next = ~xclk_reg;
        end else begin
            div_next = div_reg + nvm_port_pkg::ONE_COUNT;
        end
        unique case (state_reg)
            H_POR: begin
                cnt_next = cnt_reg + nvm_port_pkg::ONE_COUNT;
                if (cnt_reg == nvm_port_pkg::count_t'(POR_CYC - 1)) begin
                    state_next = H_IDLE;
                end
            end
            H_IDLE: begin
                if (i_start) begin
                    read_next = i_read;
                    word_next = i_word;
                    state_next = H_WAITRDY;
                end
            end
            H_WAITRDY: begin
                if (rdy_s2_reg) begin
                    oe_next = ~read_reg;
                    state_next = H_SETUP;
                end
            end
            H_SETUP: begin
                // Data leads the strobe by a cycle to survive the synchronisers
                strobe_n_next = 1'b0;
                state_next = H_LOW;
            end
            H_LOW: begin
                if (!rdy_s2_reg) begin
                    rdata_next = bus_s2_reg;
                    strobe_n_next = 1'b1;
                    oe_next = 1'b0;
                    state_next = H_HIGH;
                end
            end
            H_HIGH: begin
                if (rdy_s2_reg) begin
                    done_next = 1'b1;
                    state_next = H_IDLE;
                end
            end
            default: state_next = H_IDLE;
        endcase
    end

    // Register the next values
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= H_POR;
            cnt_reg <= nvm_port_pkg::ZERO_COUNT;
            div_reg <= nvm_port_pkg::ZERO_COUNT;
            xclk_reg <= 1'b0;
            read_reg <= 1'b0;
            word_reg <= nvm_port_pkg::ZERO_WORD;
            strobe_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= nvm_port_pkg::ZERO_WORD;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            xclk_reg <= xclk_next;
            read_reg <= read_next;
            word_reg <= word_next;
            strobe_n_reg <= strobe_n_next;
            oe_reg <= oe_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs
    assign link.command_strobe_n = strobe_n_reg;
    assign link.read_select = read_reg;
    assign link.external_clock_input = xclk_reg;
    assign link.host_data = word_reg;
    assign link.host_oe = oe_reg;
    assign o_req_ready = (state_reg == H_IDLE);
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
endmodule : nvm_prog_host
`default_nettype wire

/* nvm_port_checker.sv */
// Pin checker for the programming port, fed by the tb beside the link.
// Assumes one shared clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module nvm_port_checker #(
    parameter int DETECT_CYC = 3 * nvm_port_pkg::EXT_PERIOD_MAX_CYC,
    parameter int POR_CYC = nvm_port_pkg::POR_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Link pins
    input wire logic command_strobe_n,
    input wire logic read_select,
    input wire logic ready,
    input wire logic host_oe,
    input wire logic dev_oe
);
    // Cycles since reset release; saturates so it never wraps
    logic [15:0] up_reg;
    logic [15:0] up_next;
    always_comb begin
        up_next = (up_reg == 16'hffff) ? up_reg : up_reg + 16'h0001;
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            up_reg <= 16'h0000;
        end else begin
            up_reg <= up_next;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Margin of two cycles: the counter lags the release edge
    AST_DETECT_HOLD: assert property (int'(up_reg) < DETECT_CYC - 2 |-> !ready)
        else $error("ready rose during clock detection");
    // The programmer keeps the strobe high through its power-on wait
    AST_POR_WAIT: assert property (int'(up_reg) < POR_CYC |-> command_strobe_n)
        else $error("strobe fell during power-on wait");
    AST_TAKE: assert property ($fell(command_strobe_n) && ready |-> ##[1:4] !ready)
        else $error("strobe fall not taken");
    AST_BUSY: assert property ($fell(ready) |=> !ready [*8])
        else $error("ready back too soon");
    AST_START_RDY: assert property ($fell(command_strobe_n) |-> ready)
        else $error("strobe fell while not ready");
    AST_HOLD_LOW: assert property (!ready && !command_strobe_n |=> !ready)
        else $error("ready rose with strobe low");
    AST_RETURN: assert property ($rose(command_strobe_n) |-> ##[1:20] ready)
        else $error("ready did not return");
    AST_READ_OE: assert property ($fell(ready) && read_select |-> dev_oe)
        else $error("read not driven by device");
    AST_WRITE_OE: assert property ($fell(ready) && !read_select |-> !dev_oe && host_oe)
        else $error("write bus drive wrong");
    AST_ONE_DRIVER: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the bus");
    // Main traffic kinds
    COV_READ: cover property ($fell(ready) && read_select);
    COV_WRITE: cover property ($fell(ready) && !read_select);
    COV_DONE: cover property ($rose(ready));
endmodule : nvm_port_checker
`default_nettype wire

/* tb.sv */
// Bench joining both ends of the programming port, checker on the pins.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic ext_en = 1'b0;
    logic start = 1'b0;
    logic rd = 1'b0;
    nvm_port_pkg::word_t word = 16'h0000;
    logic req_ready, done, clk_sel, sec, ign;
    nvm_port_pkg::word_t rdata, lock_bits, gp_bits, lock_m, gp_m, got, a;
    nvm_port_pkg::word_t cmds [4];
    int n_errors = 0;
    int tests_run = 0;
    int ign_cnt = 0;
    int n = 0;
    int cyc = 0;
    // Version word given to the device, arbitrary value
    localparam nvm_port_pkg::word_t VERSION_W = 16'h00c3;
    nvm_port_if link();
    nvm_prog_device #(.DETECT_CYC(200), .VERSION_CODE(VERSION_W)) u_nvm_prog_device (
        .i_clk(i_clk), .i_resetn(i_resetn), .link(link), .o_ext_clock_sel(clk_sel),
        .o_lock_bits(lock_bits), .o_gp_bits(gp_bits), .o_security(sec), .o_cmd_ignored(ign));
    nvm_prog_host #(.POR_CYC(20)) u_nvm_prog_host (
        .i_clk(i_clk), .i_resetn(i_resetn), .link(link), .i_ext_clock_en(ext_en),
        .i_start(start), .i_read(rd), .i_word(word), .o_req_ready(req_ready),
        .o_done(done), .o_rdata(rdata));
    nvm_port_checker #(.DETECT_CYC(200), .POR_CYC(20)) u_nvm_port_checker (
        .i_clk(i_clk), .i_resetn(i_resetn), .command_strobe_n(link.command_strobe_n),
        .read_select(link.read_select), .ready(link.ready), .host_oe(link.host_oe),
        .dev_oe(link.dev_oe));
    always #10 i_clk = ~i_clk;
    // Run limit well above the expected few thousand cycles; also counts ignore pulses
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (ign === 1'b1) ign_cnt <= ign_cnt + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end
    task automatic check(input nvm_port_pkg::word_t seen, input nvm_port_pkg::word_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One handshake through the host user port; start pulsed for one cycle, then waits for done
    task automatic xfer(input logic r, input nvm_port_pkg::word_t w);
        @(negedge i_clk);
        while (req_ready !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        start <= 1'b1;
        rd <= r;
        word <= w;
        @(posedge i_clk);
        start <= 1'b0;
        @(negedge i_clk);
        while (done !== 1'b1) @(negedge i_clk);
    endtask : xfer
    // A get is a command write followed by a read handshake
    task automatic get(input nvm_port_pkg::word_t c);
        xfer(1'b0, c);
        xfer(1'b1, 16'h0000);
        got = rdata;
    endtask : get
    function automatic nvm_port_pkg::word_t upd(input nvm_port_pkg::word_t v,
        input nvm_port_pkg::word_t x, input logic b);
        upd = v;
        upd[x[3:0]] = b;
    endfunction : upd
    // Command plus argument word, then the model follows and outputs are compared
    task automatic op(input nvm_port_pkg::word_t c, input nvm_port_pkg::word_t x);
        xfer(1'b0, c);
        xfer(1'b0, x);
        case (c)
            nvm_port_pkg::CMD_SET_LOCK: lock_m = upd(lock_m, x, 1'b1);
            nvm_port_pkg::CMD_CLEAR_LOCK: lock_m = upd(lock_m, x, 1'b0);
            nvm_port_pkg::CMD_SET_GP_BIT: gp_m = upd(gp_m, x, 1'b1);
            nvm_port_pkg::CMD_CLEAR_GP_BIT: gp_m = upd(gp_m, x, 1'b0);
            nvm_port_pkg::CMD_ERASE_WRITE_LOCK: lock_m = upd(lock_m, x, 1'b1);
            default: ;
        endcase
        check(lock_bits, lock_m);
        check(gp_bits, gp_m);
    endtask : op
    // Reset with or without the external clock, then the clock choice is read back
    task automatic do_reset(input logic e);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        ext_en <= e;
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        lock_m = 16'h0000;
        gp_m = 16'h0000;
        repeat (260) @(posedge i_clk);
        check({15'h0000, clk_sel}, {15'h0000, e});
    endtask : do_reset
    task automatic final_report();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32'h02f7d517));
        cmds = '{nvm_port_pkg::CMD_SET_LOCK, nvm_port_pkg::CMD_CLEAR_LOCK,
                 nvm_port_pkg::CMD_SET_GP_BIT, nvm_port_pkg::CMD_CLEAR_GP_BIT};
        do_reset(1'b0);
        do_reset(1'b1);
        get(nvm_port_pkg::CMD_GET_VERSION);
        check(got, VERSION_W);
        // Edge indices first, then random words whose low nibble picks the bit
        for (int i = 0; i < 24; i++) begin
            a = (i < 4) ? 16'h000f : ((i < 8) ? 16'h0000 : 16'($urandom()));
            op(cmds[i % 4], a);
        end
        get(nvm_port_pkg::CMD_GET_LOCK);
        check(got, lock_m);
        get(nvm_port_pkg::CMD_GET_GP_BIT);
        check(got, gp_m);
        get(nvm_port_pkg::CMD_GET_SECURITY);
        check(got, 16'h0000);
        xfer(1'b0, nvm_port_pkg::CMD_SET_SECURITY);
        get(nvm_port_pkg::CMD_GET_SECURITY);
        check(got, 16'h0001);
        check({15'h0000, sec}, 16'h0001);
        // Page write then erase-write-lock on a page left unlocked
        op(nvm_port_pkg::CMD_CLEAR_LOCK, 16'h0009);
        op(nvm_port_pkg::CMD_WRITE_MEMORY, 16'h5a5a);
        op(nvm_port_pkg::CMD_ERASE_WRITE_LOCK, 16'h0009);
        check(u_nvm_prog_device.mem_reg[9], 16'h5a5a);
        // Unknown code and a relock of a locked page are refused; select is a quiet no-op
        n = ign_cnt;
        xfer(1'b0, 16'h00ff);
        xfer(1'b0, nvm_port_pkg::CMD_SELECT_CONTROLLER);
        op(nvm_port_pkg::CMD_WRITE_MEMORY, 16'h1234);
        op(nvm_port_pkg::CMD_ERASE_WRITE_LOCK, 16'h0009);
        repeat (2) @(negedge i_clk);
        check(16'(ign_cnt - n), 16'h0002);
        check(u_nvm_prog_device.mem_reg[9], 16'h5a5a);
        // Erase all keeps the general-purpose bits
        xfer(1'b0, nvm_port_pkg::CMD_ERASE_ALL);
        repeat (2) @(negedge i_clk);
        check(lock_bits, 16'h0000);
        check({15'h0000, sec}, 16'h0000);
        check(gp_bits, gp_m);
        check(u_nvm_prog_device.mem_reg[9], 16'h0000);
        final_report();
    end
endmodule : tb
`default_nettype wire
